// ### hdl/hpc_device_end.sv
/*
 * Device end of the multiplexed host port control pins: strap-selected pin
 * function, address strobe capture, byte pairing, register access decode.
 * Assumes all link inputs synchronous to clk and a memory that answers
 * memRdData combinationally from memRdAddr.
 */
// Function
// R1 - Strap low: pin zero is io bit 44
// R2 - Strap high: pin zero is address strobe
// R3 - Address strobe latches bus into address register
// R4 - Address strobe ignored outside multiplexed mode
// R5 - Strap sampled in reset, applied at release
// R6 - Strap low: pin one is io bit 45
// R7 - Strap high: pin one is byte identify
// R8 - Host marks first and second byte
// R9 - Access select picks one of four registers
// R10 - Access select pins are inputs after reset
// R11 - Respond only while chip select low
// R12 - Host waits for port reset release
// R13 - Read/write select sets transfer direction
// R14 - Chip select and read/write are inputs
// R15 - Each host cycle is two byte transfers
// R16 - Port enable low disables whole port
// R17 - Select codes: ctrl, data inc, addr, data
// R18 - Read/write high means read
`include "hpc_map.svh"
module hpc_device_end
  import hpc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              strapPin,
  hpc_if.device                  link,
  input  wire logic [1:0]        ioDirIn,
  input  wire logic [1:0]        ioOutIn,
  output logic      [1:0]        ioPinVal,
  output logic                   hostModeOut,
  output logic      [15:0]       ctrlOut,
  output logic      [ADDR_W-1:0] addrOut,
  output logic                   memWrEn,
  output logic      [ADDR_W-1:0] memWrAddr,
  output logic      [15:0]       memWrData,
  output logic      [ADDR_W-1:0] memRdAddr,
  input  wire logic [15:0]       memRdData
);

  if (ADDR_W != 16) begin : g_chk
    $error("hpc_device_end: ADDR_W must be 16");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  logic              mode_reg,     mode_next;
  logic              active_reg,   active_next;
  logic              prevDs_reg,   prevDs_next;
  logic              prevAs_reg,   prevAs_next;
  logic [7:0]        hiByte_reg,   hiByte_next;
  logic [15:0]       ctrl_reg,     ctrl_next;
  logic [ADDR_W-1:0] addr_reg,     addr_next;
  logic              memWe_reg,    memWe_next;
  logic [ADDR_W-1:0] memWa_reg,    memWa_next;
  logic [15:0]       memWd_reg,    memWd_next;
  logic [7:0]        dOut_reg,     dOut_next;
  logic              dOe_reg,      dOe_next;
  logic [1:0]        ioOe_reg,     ioOe_next;
  logic [1:0]        ioOut_reg,    ioOut_next;
  logic [1:0]        ioVal_reg,    ioVal_next;

  logic              portOn;
  logic              selected;
  logic              byteTaken;
  logic              asFall;
  logic [15:0]       word;
  logic [15:0]       readWord;
  hpc_target_t       target;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    mode_next   = mode_reg;
    active_next = 1'b1;
    prevDs_next = link.dataStrobeN;
    prevAs_next = link.ctl0Line;
    hiByte_next = hiByte_reg;
    ctrl_next   = ctrl_reg;
    addr_next   = addr_reg;
    memWe_next  = 1'b0;
    memWa_next  = memWa_reg;
    memWd_next  = memWd_reg;
    ioOe_next   = 2'h0;
    ioOut_next  = ioOutIn;
    ioVal_next  = {link.ctl1Line, link.ctl0Line};
    if (srst) begin
      mode_next = strapPin;                               // [R5]
    end
    portOn = active_reg && (mode_reg == `HPC_STRAP_HOST)
             && link.portEnable;                          // [R16]
    selected = portOn && (link.chipSelN == `HPC_CS_ACTIVE); // [R11]
    byteTaken = selected && prevDs_reg && !link.dataStrobeN;
    asFall = selected && prevAs_reg && !link.ctl0Line;    // [R2] [R4]
    target = hpc_decode(link.accessSel);                  // [R9] [R17]
    word = {hiByte_reg, link.dataLine};
    if (asFall) begin
      if (link.ctl1Line == `HPC_BYTE_FIRST) begin          // [R3]
        addr_next[15:8] = link.dataLine;
      end else begin
        addr_next[7:0] = link.dataLine;
      end
    end
    if (byteTaken) begin
      if (link.ctl1Line == `HPC_BYTE_FIRST) begin          // [R7] [R15]
        if (link.readWrite == `HPC_RW_WRITE) begin
          hiByte_next = link.dataLine;
        end
      end else begin
        if (link.readWrite == `HPC_RW_WRITE) begin        // [R13] [R18]
          case (target)
            HPC_TGT_CTRL: begin
              ctrl_next = word;
            end
            HPC_TGT_ADDR: begin
              addr_next = word;
            end
            default: begin
              memWe_next = 1'b1;
              memWa_next = addr_reg;
              memWd_next = word;
            end
          endcase
        end
        if (target == HPC_TGT_DATA_INC) begin
          addr_next = addr_reg + 16'h0001;
        end
      end
    end
    case (target)
      HPC_TGT_CTRL: begin
        readWord = ctrl_reg;
      end
      HPC_TGT_ADDR: begin
        readWord = addr_reg;
      end
      default: begin
        readWord = memRdData;
      end
    endcase
    dOut_next = (link.ctl1Line == `HPC_BYTE_FIRST) ? readWord[15:8]
                                                 : readWord[7:0];
    dOe_next = selected && (link.readWrite == `HPC_RW_READ); // [R13]
    if (active_reg && (mode_reg != `HPC_STRAP_HOST)) begin
      ioOe_next = ioDirIn;                                // [R1] [R6]
    end
    if (srst) begin
      active_next = 1'b0;
      hiByte_next = `HPC_BYTE_RESET;
      ctrl_next   = `HPC_WORD_RESET;
      addr_next   = `HPC_WORD_RESET;
      memWe_next  = 1'b0;
      memWa_next  = `HPC_WORD_RESET;
      memWd_next  = `HPC_WORD_RESET;
      dOut_next   = `HPC_BYTE_RESET;
      dOe_next    = 1'b0;                                 // [R10] [R14]
      ioOe_next   = 2'h0;
      ioOut_next  = 2'h0;
      prevDs_next = `HPC_LINE_IDLE;
      prevAs_next = `HPC_LINE_IDLE;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    mode_reg   <= mode_next;
    active_reg <= active_next;
    prevDs_reg <= prevDs_next;
    prevAs_reg <= prevAs_next;
    hiByte_reg <= hiByte_next;
    ctrl_reg   <= ctrl_next;
    addr_reg   <= addr_next;
    memWe_reg  <= memWe_next;
    memWa_reg  <= memWa_next;
    memWd_reg  <= memWd_next;
    dOut_reg   <= dOut_next;
    dOe_reg    <= dOe_next;
    ioOe_reg   <= ioOe_next;
    ioOut_reg  <= ioOut_next;
    ioVal_reg  <= ioVal_next;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.ctl0DevOut = ioOut_reg[0];
  assign link.ctl0DevOe  = ioOe_reg[0];
  assign link.ctl1DevOut = ioOut_reg[1];
  assign link.ctl1DevOe  = ioOe_reg[1];
  assign link.dataDevOut = dOut_reg;
  assign link.dataDevOe  = dOe_reg;
  assign ioPinVal        = ioVal_reg;
  assign hostModeOut     = mode_reg;
  assign ctrlOut         = ctrl_reg;
  assign addrOut         = addr_reg;
  assign memWrEn         = memWe_reg;
  assign memWrAddr       = memWa_reg;
  assign memWrData       = memWd_reg;
  assign memRdAddr       = addr_reg;

endmodule : hpc_device_end

// ### pkg/hpc_map.svh
/*
 * Constants of the multiplexed host port control pins: access-select codes,
 * byte identification levels, read/write levels and timing counts.
 * Assumes inclusion by bare name from the port package.
 */
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH

// ****************************************************************
// Access select codes
// ****************************************************************
`define HPC_SEL_CTRL      2'h0
`define HPC_SEL_DATA_INC  2'h1
`define HPC_SEL_ADDR      2'h2
`define HPC_SEL_DATA      2'h3

// ****************************************************************
// Pin levels
// ****************************************************************
`define HPC_RW_READ       1'h1
`define HPC_RW_WRITE      1'h0
`define HPC_BYTE_FIRST    1'h0
`define HPC_BYTE_SECOND   1'h1
`define HPC_STRAP_HOST    1'h1
`define HPC_CS_ACTIVE     1'h0
`define HPC_LINE_IDLE     1'h1

// ****************************************************************
// Reset values, io bit numbers and timing counts
// ****************************************************************
`define HPC_WORD_RESET    16'h0000
`define HPC_BYTE_RESET    8'h00
`define HPC_IO_BIT_A      44
`define HPC_IO_BIT_B      45
`define HPC_STROBE_CYC    3'h2
`define HPC_HOST_WAIT     4'h4

`endif

// ### pkg/hpc_pkg.sv
/*
 * Types shared by both ends of the host port control link.
 * Assumes hpc_map.svh is on the include path.
 */
`include "hpc_map.svh"

package hpc_pkg;

  // ****************************************************************
  // Register targets and host sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    HPC_TGT_CTRL,
    HPC_TGT_DATA_INC,
    HPC_TGT_ADDR,
    HPC_TGT_DATA
  } hpc_target_t;

  typedef enum logic [2:0] {
    HPC_H_RESET,
    HPC_H_IDLE,
    HPC_H_SETUP,
    HPC_H_STROBE,
    HPC_H_HOLD,
    HPC_H_DONE
  } hpc_hstate_t;

  function automatic hpc_target_t hpc_decode(input logic [1:0] sel);
    hpc_target_t t;
    t = HPC_TGT_CTRL;
    if (sel == `HPC_SEL_DATA_INC) begin
      t = HPC_TGT_DATA_INC;
    end else if (sel == `HPC_SEL_ADDR) begin
      t = HPC_TGT_ADDR;
    end else if (sel == `HPC_SEL_DATA) begin
      t = HPC_TGT_DATA;
    end
    return t;
  endfunction : hpc_decode

endpackage : hpc_pkg

// ### pkg/hpc_if.sv
/*
 * Link between the host and the device end of the host port.
 * Two-way lines are resolved here from both drivers' enables; an
 * undriven line reads high as if pulled up.
 */
interface hpc_if;

  logic       ctl0HostOut;
  logic       ctl0HostOe;
  logic       ctl0DevOut;
  logic       ctl0DevOe;
  logic       ctl0Line;
  logic       ctl1HostOut;
  logic       ctl1HostOe;
  logic       ctl1DevOut;
  logic       ctl1DevOe;
  logic       ctl1Line;
  logic [7:0] dataHostOut;
  logic       dataHostOe;
  logic [7:0] dataDevOut;
  logic       dataDevOe;
  logic [7:0] dataLine;
  logic [1:0] accessSel;
  logic       chipSelN;
  logic       readWrite;
  logic       dataStrobeN;
  logic       portEnable;

  // ****************************************************************
  // Line resolution
  // ****************************************************************
  assign ctl0Line = ctl0HostOe ? ctl0HostOut : (ctl0DevOe ? ctl0DevOut : 1'b1);
  assign ctl1Line = ctl1HostOe ? ctl1HostOut : (ctl1DevOe ? ctl1DevOut : 1'b1);
  assign dataLine = dataHostOe ? dataHostOut :
                    (dataDevOe ? dataDevOut : 8'hff);

  modport device (
    input  ctl0Line, ctl1Line, dataLine, accessSel, chipSelN, readWrite,
    input  dataStrobeN, portEnable,
    output ctl0DevOut, ctl0DevOe, ctl1DevOut, ctl1DevOe, dataDevOut, dataDevOe
  );

  modport host (
    input  ctl0Line, ctl1Line, dataLine,
    output ctl0HostOut, ctl0HostOe, ctl1HostOut, ctl1HostOe,
    output dataHostOut, dataHostOe, accessSel, chipSelN, readWrite,
    output dataStrobeN, portEnable
  );

endinterface : hpc_if

// ### hdl/hpc_host_end.sv
/*
 * Host end of the multiplexed host port: turns one word command into a
 * two-byte host cycle with byte identify, access select and strobes.
 * Assumes the device end is strapped for host port mode.
 */
`include "hpc_map.svh"
module hpc_host_end
  import hpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  hpc_if.host              link,
  input  wire logic        cmdValid,
  input  wire logic        cmdRead,
  input  wire logic [1:0]  cmdSel,
  input  wire logic [15:0] cmdData,
  output logic             cmdReady,
  output logic             rspValid,
  output logic      [15:0] rspData
);

  // ****************************************************************
  // State
  // ****************************************************************
  hpc_hstate_t st_reg, st_next;
  logic [3:0]  wait_reg,  wait_next;
  logic [2:0]  cnt_reg,   cnt_next;
  logic        idx_reg,   idx_next;
  logic        rd_reg,    rd_next;
  logic [1:0]  sel_reg,   sel_next;
  logic [15:0] word_reg,  word_next;
  logic        csN_reg,   csN_next;
  logic        dsN_reg,   dsN_next;
  logic        asN_reg,   asN_next;
  logic        en_reg,    en_next;
  logic        dOe_reg,   dOe_next;
  logic        rdy_reg,   rdy_next;
  logic        rv_reg,    rv_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next   = st_reg;
    wait_next = wait_reg;
    cnt_next  = cnt_reg;
    idx_next  = idx_reg;
    rd_next   = rd_reg;
    sel_next  = sel_reg;
    word_next = word_reg;
    csN_next  = csN_reg;
    dsN_next  = 1'b1;
    asN_next  = 1'b1;
    en_next   = 1'b1;                                     // [R16]
    dOe_next  = dOe_reg;
    rdy_next  = 1'b0;
    rv_next   = 1'b0;
    case (st_reg)
      HPC_H_RESET: begin
        wait_next = wait_reg + 4'h1;
        if (wait_reg == `HPC_HOST_WAIT) begin              // [R12]
          st_next  = HPC_H_IDLE;
          rdy_next = 1'b1;
        end
      end
      HPC_H_IDLE: begin
        rdy_next = 1'b1;
        if (cmdValid && rdy_reg) begin
          rdy_next  = 1'b0;
          rd_next   = cmdRead;
          sel_next  = cmdSel;
          word_next = cmdData;
          idx_next  = `HPC_BYTE_FIRST;
          st_next   = HPC_H_SETUP;
        end
      end
      HPC_H_SETUP: begin
        csN_next = `HPC_CS_ACTIVE;                         // [R11]
        dOe_next = (rd_reg == `HPC_RW_WRITE);              // [R13] [R18]
        cnt_next = 3'h0;
        st_next  = HPC_H_STROBE;
      end
      HPC_H_STROBE: begin
        dsN_next = 1'b0;
        asN_next = !((hpc_decode(sel_reg) == HPC_TGT_ADDR)
                   && (rd_reg == `HPC_RW_WRITE));          // [R3]
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == `HPC_STROBE_CYC) begin
          dsN_next = 1'b1;
          asN_next = 1'b1;
          if (rd_reg == `HPC_RW_READ) begin
            if (idx_reg == `HPC_BYTE_FIRST) begin
              word_next[15:8] = link.dataLine;
            end else begin
              word_next[7:0] = link.dataLine;
            end
          end
          st_next = HPC_H_HOLD;
        end
      end
      HPC_H_HOLD: begin
        if (idx_reg == `HPC_BYTE_FIRST) begin              // [R8] [R15]
          idx_next = `HPC_BYTE_SECOND;
          st_next  = HPC_H_SETUP;
        end else begin
          csN_next = !`HPC_CS_ACTIVE;
          dOe_next = 1'b0;
          st_next  = HPC_H_DONE;
        end
      end
      default: begin
        rv_next  = rd_reg;
        rdy_next = 1'b1;
        st_next  = HPC_H_IDLE;
      end
    endcase
    if (srst) begin
      st_next   = HPC_H_RESET;
      wait_next = 4'h0;
      cnt_next  = 3'h0;
      idx_next  = `HPC_BYTE_FIRST;
      rd_next   = `HPC_RW_WRITE;
      sel_next  = `HPC_SEL_CTRL;
      word_next = `HPC_WORD_RESET;
      csN_next  = !`HPC_CS_ACTIVE;
      dsN_next  = 1'b1;
      asN_next  = 1'b1;
      en_next   = 1'b0;
      dOe_next  = 1'b0;
      rdy_next  = 1'b0;
      rv_next   = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    st_reg   <= st_next;
    wait_reg <= wait_next;
    cnt_reg  <= cnt_next;
    idx_reg  <= idx_next;
    rd_reg   <= rd_next;
    sel_reg  <= sel_next;
    word_reg <= word_next;
    csN_reg  <= csN_next;
    dsN_reg  <= dsN_next;
    asN_reg  <= asN_next;
    en_reg   <= en_next;
    dOe_reg  <= dOe_next;
    rdy_reg  <= rdy_next;
    rv_reg   <= rv_next;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.ctl0HostOut = asN_reg;
  assign link.ctl0HostOe  = en_reg;
  assign link.ctl1HostOut = idx_reg;
  assign link.ctl1HostOe  = en_reg;
  assign link.dataHostOut = (idx_reg == `HPC_BYTE_FIRST) ? word_reg[15:8]
                                                       : word_reg[7:0];
  assign link.dataHostOe  = dOe_reg;
  assign link.accessSel   = sel_reg;                       // [R9]
  assign link.chipSelN    = csN_reg;
  assign link.readWrite   = rd_reg;
  assign link.dataStrobeN = dsN_reg;
  assign link.portEnable  = en_reg;
  assign cmdReady         = rdy_reg;
  assign rspValid         = rv_reg;
  assign rspData          = word_reg;

endmodule : hpc_host_end

// ### verification/hpc_link_props.sv
/*
 * Concurrent checks on the link between host end and device end.
 * Assumes the device end is strapped for host port mode.
 */
module hpc_link_props (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ctl0DevOe,
  input wire logic       ctl1DevOe,
  input wire logic       dataDevOe,
  input wire logic       ctl1Line,
  input wire logic [1:0] accessSel,
  input wire logic       chipSelN,
  input wire logic       readWrite,
  input wire logic       dataStrobeN,
  input wire logic       portEnable
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk);
  endclocking

  // ****************************************************************
  // Reset and selection
  // ****************************************************************
  reset_quiet_a: assert property (
    srst |=> !ctl0DevOe && !ctl1DevOe && !dataDevOe && !portEnable && chipSelN)
    else $error("link driven during reset");
  host_wait_a: assert property (
    disable iff (srst) $fell(srst) |-> chipSelN [*6])
    else $error("host selected port too soon after reset");
  drive_cause_a: assert property (
    disable iff (srst) dataDevOe |->
      !$past(chipSelN) && $past(readWrite) && $past(portEnable))
    else $error("device drives data without selected read");
  read_drive_a: assert property (
    disable iff (srst) (!chipSelN && readWrite && portEnable) [*2]
      |-> dataDevOe)
    else $error("device silent on selected read");

  // ****************************************************************
  // Host cycle framing
  // ****************************************************************
  strobe_sel_a: assert property (
    disable iff (srst) !dataStrobeN |-> !chipSelN && portEnable)
    else $error("byte strobe outside selection");
  strobe_len_a: assert property (
    disable iff (srst) $fell(dataStrobeN) |-> !dataStrobeN [*2] ##1 dataStrobeN)
    else $error("byte strobe length wrong");
  byte_pair_a: assert property (
    disable iff (srst) $fell(dataStrobeN) && !ctl1Line
      |-> ##[4:12] ($fell(dataStrobeN) && ctl1Line))
    else $error("first byte not followed by second byte");
  sel_stable_a: assert property (
    disable iff (srst) !chipSelN && !$past(chipSelN)
      |-> $stable(accessSel) && $stable(readWrite))
    else $error("select or direction changed in host cycle");

endmodule : hpc_link_props

// ### verification/testbench.sv
/*
 * Self-checking bench: host end and device end joined by one link, plus a
 * second device end driven directly by the bench on a second link.
 * Assumes hpc_map.svh on the include path.
 */
`include "hpc_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, srst, srst2, strap2, memWrEn, hostModeOut, hostModeOut2;
  logic        cmdValid, cmdRead, cmdReady, rspValid;
  logic [1:0]  cmdSel, ioPinVal2, ioDir2, ioOut2;
  logic [15:0] cmdData, rspData, ctrlOut, addrOut, addrOut2;
  logic [15:0] memWrAddr, memWrData, memRdAddr, lfsr, expAddr, expCtrl;
  logic [15:0] wrA, wrD;
  int          fails, num_checks, wrCnt = 0;

  hpc_if lk ();
  hpc_if lk2 ();

  function automatic logic [15:0] memf(input logic [15:0] a);
    return {a[7:0], ~a[15:8]};
  endfunction : memf

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // ****************************************************************
  // Design ends and checker
  // ****************************************************************
  hpc_device_end hpc_device_end_i (.clk(clk), .srst(srst), .strapPin(1'b1),
    .link(lk.device), .ioDirIn(2'h0), .ioOutIn(2'h0), .ioPinVal(),
    .hostModeOut(hostModeOut), .ctrlOut(ctrlOut), .addrOut(addrOut),
    .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .memRdAddr(memRdAddr), .memRdData(memf(memRdAddr)));
  hpc_device_end hpc_device_end_i2 (.clk(clk), .srst(srst2),
    .strapPin(strap2), .link(lk2.device), .ioDirIn(ioDir2),
    .ioOutIn(ioOut2), .ioPinVal(ioPinVal2), .hostModeOut(hostModeOut2),
    .ctrlOut(), .addrOut(addrOut2), .memWrEn(), .memWrAddr(),
    .memWrData(), .memRdAddr(), .memRdData(16'h0000));
  hpc_host_end hpc_host_end_i (.clk(clk), .srst(srst), .link(lk.host),
    .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdSel(cmdSel),
    .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspData(rspData));
  hpc_link_props chk_i (.clk(clk), .srst(srst), .ctl0DevOe(lk.ctl0DevOe),
    .ctl1DevOe(lk.ctl1DevOe), .dataDevOe(lk.dataDevOe),
    .ctl1Line(lk.ctl1Line), .accessSel(lk.accessSel),
    .chipSelN(lk.chipSelN), .readWrite(lk.readWrite),
    .dataStrobeN(lk.dataStrobeN), .portEnable(lk.portEnable));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (memWrEn === 1'b1) begin
      wrCnt <= wrCnt + 1;
      wrA <= memWrAddr;
      wrD <= memWrData;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_cmd(input logic rd, input logic [1:0] sel,
                        input logic [15:0] d);
    int n;
    int w0;
    logic [15:0] ea;
    n = 0;
    w0 = wrCnt;
    ea = expAddr;
    @(negedge clk);
    while (cmdReady !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    cmdValid = 1'b1;
    cmdRead = rd;
    cmdSel = sel;
    cmdData = d;
    @(negedge clk);
    cmdValid = 1'b0;
    n = 0;
    while (cmdReady !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < 40), 16'h0001, "command done");
    if (rd) begin
      chk(16'(rspValid), 16'h0001, "read answer");
      chk(rspData, (sel == `HPC_SEL_CTRL) ? expCtrl :
          (sel == `HPC_SEL_ADDR) ? expAddr : memf(expAddr), "read data");
    end
    repeat (3) @(negedge clk);
    if (!rd && sel == `HPC_SEL_CTRL) expCtrl = d;
    if (!rd && sel == `HPC_SEL_ADDR) expAddr = d;
    if (!rd && sel[0]) begin
      chk(16'(wrCnt - w0), 16'h0001, "write count");
      chk(wrA, ea, "write address");
      chk(wrD, d, "write data");
    end
    if (sel == `HPC_SEL_DATA_INC) expAddr = expAddr + 16'h0001;
    chk(addrOut, expAddr, "address register");
    chk(ctrlOut, expCtrl, "control register");
  endtask : do_cmd

  task automatic strobe_addr(input logic [7:0] b, input logic second,
                             input logic csn, input logic pe);
    @(negedge clk);
    lk2.portEnable = pe;
    lk2.chipSelN = csn;
    lk2.dataHostOut = b;
    lk2.dataHostOe = 1'b1;
    lk2.ctl1HostOe = 1'b1;
    lk2.ctl1HostOut = second;
    lk2.ctl0HostOe = 1'b1;
    lk2.ctl0HostOut = 1'b1;
    @(negedge clk);
    lk2.ctl0HostOut = 1'b0;
    repeat (2) @(negedge clk);
    lk2.ctl0HostOut = 1'b1;
    lk2.chipSelN = 1'b1;
    lk2.dataHostOe = 1'b0;
    repeat (2) @(negedge clk);
  endtask : strobe_addr

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    srst = 1'b1;
    srst2 = 1'b1;
    strap2 = 1'b0;
    {cmdValid, cmdRead, cmdSel, cmdData} = '0;
    {ioDir2, ioOut2, lk2.dataHostOut, lk2.dataHostOe, lk2.accessSel} = '0;
    {lk2.ctl0HostOe, lk2.ctl1HostOe, lk2.readWrite, lk2.portEnable} = '0;
    {lk2.ctl0HostOut, lk2.ctl1HostOut, lk2.chipSelN} = 3'h7;
    lk2.dataStrobeN = 1'b1;
    {lfsr, expAddr, expCtrl, fails, num_checks} = '0;
    lfsr = 16'h0042;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    srst2 = 1'b0;
    chk(16'(hostModeOut), 16'h0001, "host mode");
    do_cmd(1'b0, `HPC_SEL_ADDR, 16'hffff);
    do_cmd(1'b0, `HPC_SEL_DATA_INC, 16'h1234);
    do_cmd(1'b1, `HPC_SEL_DATA_INC, 16'h0000);
    do_cmd(1'b0, `HPC_SEL_CTRL, 16'ha55a);
    do_cmd(1'b1, `HPC_SEL_CTRL, 16'h0000);
    do_cmd(1'b1, `HPC_SEL_ADDR, 16'h0000);
    do_cmd(1'b0, `HPC_SEL_DATA, 16'h00ff);
    do_cmd(1'b1, `HPC_SEL_DATA, 16'h0000);
    repeat (20) begin
      lfsr = lfsr_next(lfsr);
      do_cmd(lfsr[15], lfsr[1:0], lfsr_next(lfsr));
    end
    $display("test host commands done");
    @(negedge clk);
    {lk2.ctl0HostOe, lk2.ctl0HostOut, lk2.ctl1HostOe, lk2.ctl1HostOut} = 4'hb;
    repeat (3) @(negedge clk);
    chk(16'(ioPinVal2), 16'h0002, "io pins in");
    chk(16'(hostModeOut2), 16'h0000, "io mode");
    chk(16'({lk2.ctl0DevOe, lk2.ctl1DevOe}), 16'h0000, "io dir");
    {lk2.ctl0HostOe, lk2.ctl1HostOe, ioDir2, ioOut2} = 6'h0d;
    repeat (3) @(negedge clk);
    chk(16'(ioPinVal2), 16'h0001, "io pins out");
    ioDir2 = 2'h0;
    strobe_addr(8'h9a, 1'b0, 1'b0, 1'b1);
    chk(addrOut2, 16'h0000, "strobe in io mode");
    $display("test io mode done");
    srst2 = 1'b1;
    strap2 = 1'b1;
    repeat (3) @(negedge clk);
    srst2 = 1'b0;
    @(negedge clk);
    strap2 = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(hostModeOut2), 16'h0001, "strap at release");
    chk(16'({lk2.dataDevOe, lk2.ctl0DevOe}), 16'h0000, "inputs");
    strobe_addr(8'h77, 1'b0, 1'b0, 1'b0);
    chk(addrOut2, 16'h0000, "port disabled");
    strobe_addr(8'h77, 1'b0, 1'b1, 1'b1);
    chk(addrOut2, 16'h0000, "not selected");
    strobe_addr(8'hc3, 1'b0, 1'b0, 1'b1);
    strobe_addr(8'h5e, 1'b1, 1'b0, 1'b1);
    chk(addrOut2, 16'hc35e, "address strobe");
    $display("test address strobe done");
    tally_and_finish();
  end

  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

endmodule : testbench
